// *** bench/qpbsi_host_model.sv ***
// host controller model: link clock pair, command slots, write beats, read capture
// assumes: clk at 100 MHz, link half period 62.5 ns, phase unrelated to clk
`timescale 1ns/100ps
module qpbsi_host_model (
  input wire logic clk, // system clock
  input wire logic rst_n, // reset, active low
  output logic in_clock_true, // link clock true
  output logic in_clock_comp, // link clock complement
  output logic rd_req_n, // read request, active low
  output logic wr_req_n, // write request, active low
  output logic [16:0] sync_address, // burst address
  output logic [35:0] data_in, // write beat
  output logic [3:0] byte_write_mask_n, // per-beat byte mask
  input wire logic [35:0] data_out, // read beat
  input wire logic read_data_valid, // read beats valid
  input wire logic echo_clock_true, // echo clock true
  input wire logic echo_clock_comp, // echo clock complement
  input wire logic wr_buf_ready // write buffer room
);
  // ----------------------------------------
  // link clocks and pin drive
  // ----------------------------------------
  logic [178:0] cmd_q[$];
  logic [35:0] rd_q[$];
  logic [39:0] slot[0:5];
  logic sv[0:5];
  logic [178:0] c;
  logic tr, pt, pc, pv;
  int lost, e_cnt;
  realtime t_iss, t_lat;

  initial begin
    in_clock_true = 1'b0;
    in_clock_comp = 1'b1;
    rd_req_n = 1'b1;
    wr_req_n = 1'b1;
    sync_address = '0;
    data_in = '0;
    byte_write_mask_n = '1;
    lost = 0;
    e_cnt = 0;
    pt = 1'b0;
    pc = 1'b1;
    pv = 1'b0;
    foreach (sv[i]) sv[i] = 1'b0;
    // offset keeps link edges off every clk edge
    #1.3;
    forever begin
      #62.5;
      in_clock_true = ~in_clock_true;
      in_clock_comp = ~in_clock_true;
    end
  end

  // pins change mid-phase, well clear of the link rising edges
  always begin
    @(posedge in_clock_true or posedge in_clock_comp);
    tr = in_clock_true;
    repeat (4) @(posedge clk);
    if (sv[0]) begin
      if (!wr_buf_ready) lost++;
      data_in <= slot[0][39:4];
      byte_write_mask_n <= slot[0][3:0];
    end else begin
      data_in <= ~data_in;
      byte_write_mask_n <= ~byte_write_mask_n;
    end
    for (int i = 0; i < 5; i++) begin
      slot[i] = slot[i+1];
      sv[i] = sv[i+1];
    end
    sv[5] = 1'b0;
    if (!tr) begin
      c = '0;
      if (cmd_q.size() > 0) c = cmd_q.pop_front();
      rd_req_n <= ~c[178];
      wr_req_n <= ~c[177];
      sync_address <= (c[178] | c[177]) ? c[176:160] : ~sync_address;
      if (c[178]) t_iss = $realtime;
      // beats from the next true rise on, comp rise in between
      for (int b = 0; b < 4; b++) begin
        if (c[177] && !c[178]) begin
          slot[1+b] = {c[16+36*b +: 36], c[4*b +: 4]};
          sv[1+b] = 1'b1;
        end
      end
    end
  end

  // a beat is taken where an echo clock changes while valid is high
  always @(negedge clk) begin
    if (rst_n && read_data_valid && (echo_clock_true != pt || echo_clock_comp != pc))
      rd_q.push_back(data_out);
    if (read_data_valid && !pv) t_lat = $realtime - t_iss;
    if (echo_clock_true != pt) e_cnt++;
    pt = echo_clock_true;
    pc = echo_clock_comp;
    pv = read_data_valid;
  end
endmodule : qpbsi_host_model

// *** bench/testbench.sv ***
// self-checking bench for the burst-4 sram core
// assumes: host model drives the link side, bench drives dll_off_n
`timescale 1ns/100ps
module testbench;
  logic clk, rst_n, dll_off_n;
  logic in_clock_true, in_clock_comp, rd_req_n, wr_req_n, data_out_oe;
  logic echo_clock_true, echo_clock_comp, read_data_valid, wr_buf_ready;
  logic [16:0] sync_address;
  logic [35:0] data_in, data_out;
  logic [3:0] byte_write_mask_n;
  int num_errors, checks_done, oe_bad;
  logic [35:0] ref_mem[logic [18:0]];
  logic [35:0] exp_q[$];

  initial clk = 1'b0;
  always #5 clk = ~clk;

  qpbsi_core DUT (.clk(clk), .rst_n(rst_n), .in_clock_true(in_clock_true),
    .in_clock_comp(in_clock_comp), .rd_req_n(rd_req_n), .wr_req_n(wr_req_n),
    .dll_off_n(dll_off_n), .sync_address(sync_address), .data_in(data_in),
    .byte_write_mask_n(byte_write_mask_n), .data_out(data_out),
    .data_out_oe(data_out_oe), .echo_clock_true(echo_clock_true),
    .echo_clock_comp(echo_clock_comp), .read_data_valid(read_data_valid),
    .wr_buf_ready(wr_buf_ready));

  qpbsi_host_model host (.clk(clk), .rst_n(rst_n), .in_clock_true(in_clock_true),
    .in_clock_comp(in_clock_comp), .rd_req_n(rd_req_n), .wr_req_n(wr_req_n),
    .sync_address(sync_address), .data_in(data_in),
    .byte_write_mask_n(byte_write_mask_n), .data_out(data_out),
    .read_data_valid(read_data_valid), .echo_clock_true(echo_clock_true),
    .echo_clock_comp(echo_clock_comp), .wr_buf_ready(wr_buf_ready));

  // output enable must track the beats on data_out, settled mid-cycle
  always @(negedge clk) begin
    if (rst_n && data_out_oe !== read_data_valid) oe_bad++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task summarize;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                              input logic [3:0] m);
    merge = o;
    for (int i = 0; i < 4; i++) if (!m[i]) merge[9*i +: 9] = n[9*i +: 9];
  endfunction : merge

  function logic [143:0] pat(input logic [7:0] s);
    for (int b = 0; b < 4; b++) pat[36*b +: 36] = {s, ~s, 4'(b), s + 8'(b), ~s};
  endfunction : pat

  // ign: queue no beats here, either refused or queued by the caller
  task push(input logic rd, input logic wr, input logic [16:0] a,
            input logic [143:0] d, input logic [15:0] m, input bit ign);
    logic [18:0] k;
    for (int b = 0; b < 4; b++) begin
      k = {a, 2'(b)};
      if (wr) ref_mem[k] = merge(ref_mem.exists(k) ? ref_mem[k] : '0, d[36*b +: 36],
                                 m[4*b +: 4]);
      if (rd && !ign) exp_q.push_back(ref_mem[k]);
    end
    host.cmd_q.push_back({rd, wr, a, d, m});
  endtask : push

  task idle(input int n);
    repeat (n) push(1'b0, 1'b0, '0, '0, '0, 1'b0);
  endtask : idle

  task rd(input logic [16:0] a, input bit ign);
    push(1'b1, 1'b0, a, '0, '0, ign);
  endtask : rd

  // quiet time after the last beat shows up any extra or refused beats
  task drain(input string nm);
    int n;
    n = exp_q.size();
    for (int i = 0; i < 3000 && host.rd_q.size() < n; i++) @(posedge clk);
    repeat (40) @(posedge clk);
    chk({nm, " beat count"}, 36'(n), 36'(host.rd_q.size()));
    if (host.rd_q.size() < n) summarize;
    while (exp_q.size() > 0) chk(nm, exp_q.pop_front(), host.rd_q.pop_front());
    host.rd_q.delete();
    $display("test %s done", nm);
  endtask : drain

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_basic;
    push(1'b0, 1'b1, 17'h00010, pat(8'h3C), 16'h0000, 1'b0);
    idle(2);
    rd(17'h00010, 1'b0);
    drain("basic");
  endtask : t_basic

  task t_mask;
    push(1'b0, 1'b1, 17'h00010, pat(8'h5A), 16'h9F63, 1'b0);
    idle(1);
    rd(17'h00010, 1'b0);
    drain("mask");
  endtask : t_mask

  task t_mixed;
    push(1'b0, 1'b1, 17'h1FFFF, pat(8'h0F), 16'h0000, 1'b0);
    rd(17'h1FFFF, 1'b0);
    push(1'b0, 1'b1, 17'h00000, pat(8'hF0), 16'h0000, 1'b0);
    rd(17'h00010, 1'b0);
    idle(1);
    rd(17'h00000, 1'b0);
    idle(1);
    // write one edge after the read: its beats meet the read beats
    rd(17'h00020, 1'b1);
    push(1'b0, 1'b1, 17'h00020, pat(8'hA5), 16'h0000, 1'b0);
    for (int b = 0; b < 4; b++) exp_q.push_back(ref_mem[{17'h00020, 2'(b)}]);
    drain("mixed");
  endtask : t_mixed

  task t_refuse;
    rd(17'h00010, 1'b0);
    rd(17'h1FFFF, 1'b1);
    idle(1);
    rd(17'h1FFFF, 1'b0);
    drain("refuse");
  endtask : t_refuse

  task t_dll;
    @(posedge clk);
    dll_off_n <= 1'b0;
    repeat (20) @(posedge clk);
    rd(17'h00010, 1'b0);
    drain("dll off");
    chk("dll off latency", 36'(1), 36'(host.t_lat > 145.0 && host.t_lat < 215.0));
    dll_off_n <= 1'b1;
    repeat (20) @(posedge clk);
    rd(17'h00010, 1'b0);
    drain("dll on");
    chk("read latency", 36'(1), 36'(host.t_lat > 270.0 && host.t_lat < 340.0));
  endtask : t_dll

  task t_echo;
    int e0;
    e0 = host.e_cnt;
    repeat (500) @(posedge clk);
    @(negedge clk);
    chk("echo edges", 36'(1), 36'(host.e_cnt - e0 >= 79 && host.e_cnt - e0 <= 81));
    chk("valid idle", 36'(0), 36'(read_data_valid));
    chk("oe with valid", 36'(0), 36'(oe_bad));
    chk("lost beats", 36'(0), 36'(host.lost));
    $display("test echo done");
  endtask : t_echo

  initial begin
    rst_n = 1'b0;
    dll_off_n = 1'b1;
    num_errors = 0;
    checks_done = 0;
    oe_bad = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_basic;
    t_mask;
    t_mixed;
    t_refuse;
    t_dll;
    t_echo;
    summarize;
  end
endmodule : testbench

// *** hdl/qpbsi_cfg.svh ***
// timing and layout constants of the burst-4 sram port
// assumes: included by bare name, counts are in link half-cycles
`ifndef QPBSI_CFG_SVH
`define QPBSI_CFG_SVH

// beats per burst, fixed
`define QPBSI_BURST_LEN 4
// beat index width
`define QPBSI_BEAT_W 2
// read: half-cycles from request edge to first beat, dll running
`define QPBSI_RD_LAT_HALF 4
// read: half-cycles to first beat with dll bypassed
`define QPBSI_RD_LAT_HALF_DLLOFF 2
// write: half-cycles from request edge to first data beat
`define QPBSI_WR_LAT_HALF 2
// read pipeline length: slowest latency plus one burst
`define QPBSI_RD_PIPE 8
// write pipeline length: latency plus burst minus one
`define QPBSI_WR_PIPE 5
// synchroniser depth for all pins
`define QPBSI_SYNC_STAGES 2
// write-beat buffer depth
`define QPBSI_FIFO_DEPTH 8

`endif

// *** hdl/qpbsi_core.sv ***
// burst-4 ddr sram core: command capture, write path, read path, echo clocks
// assumes: link clock pair and all pins are asynchronous to clk and much
// slower (at least 6 clk periods per half link cycle)
`timescale 1ns/100ps
`include "qpbsi_cfg.svh"

// What this block does
// - reads and writes share the address bus on alternating true-clock edges
// - address and request strobes sampled only on true-clock rising edges
// - write beats one and three captured on true-clock rising edges
// - write beats two and four captured on complementary-clock rising edges
// - each byte written only when its mask bit for that beat enables it
// - a write with its four beats spans two full clock cycles
// - read beats one and three leave on third and fourth true edges with dll running, second and third with dll bypassed
// - read beats two and four leave on third and fourth complementary edges with dll running, second and third with dll bypassed
// - a read with its four beats spans two full clock cycles
// - every burst moves exactly four beats, length is fixed
// - separate data-in and data-out ports allow concurrent read and write
// - complementary echo clocks change together with read data
// - address and control registered on rising edges only, never falling
// - data-valid output high during read beats, aligned with echo edges
// - echo clocks run continuously, also while data output is off
// - dll disable low selects the shorter read latency
module qpbsi_core #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 36,
  parameter int MASK_W = 4,
  parameter int FIFO_DEPTH = `QPBSI_FIFO_DEPTH
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic in_clock_true, // link input clock, true
  input wire logic in_clock_comp, // link input clock, complement
  input wire logic rd_req_n, // read request, active low
  input wire logic wr_req_n, // write request, active low
  input wire logic dll_off_n, // low: dll bypassed, short latency
  input wire logic [ADDR_W-1:0] sync_address, // burst address
  input wire logic [DATA_W-1:0] data_in, // write data beat
  input wire logic [MASK_W-1:0] byte_write_mask_n, // low enables byte
  output logic [DATA_W-1:0] data_out, // read data beat
  output logic data_out_oe, // high while data_out is driven
  output logic echo_clock_true, // echo clock, true
  output logic echo_clock_comp, // echo clock, complement
  output logic read_data_valid, // read beats valid
  output logic wr_buf_ready // write buffer can take a beat
);

  // ------------------------------------------------------------
  // constants and helpers
  // ------------------------------------------------------------
  localparam int PW = 5 + ADDR_W + DATA_W + MASK_W;
  localparam int MW = ADDR_W + `QPBSI_BEAT_W;
  localparam int FW = MW + MASK_W + DATA_W;
  localparam int RP = `QPBSI_RD_PIPE;
  localparam int WP = `QPBSI_WR_PIPE;
  localparam int BL = `QPBSI_BURST_LEN;

  function automatic logic [DATA_W-1:0] byte_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [MASK_W-1:0] m_n
  );
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int i = 0; i < DATA_W; i++) begin
      if (!m_n[i / (DATA_W / MASK_W)]) begin
        r[i] = new_w[i];
      end
    end
    return r;
  endfunction : byte_merge

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // data travels with the clocks through the same two stages,
  // so a detected edge finds its data beside it
  logic [PW-1:0] pin_s1_q;
  logic [PW-1:0] pin_s2_q;
  wire [PW-1:0] pin_raw = {in_clock_true, in_clock_comp, rd_req_n,
    wr_req_n, dll_off_n, sync_address, data_in, byte_write_mask_n};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  wire s_k = pin_s2_q[PW-1];
  wire s_kn = pin_s2_q[PW-2];
  wire s_rd_n = pin_s2_q[PW-3];
  wire s_wr_n = pin_s2_q[PW-4];
  wire s_dll_n = pin_s2_q[PW-5];
  wire [ADDR_W-1:0] s_addr = pin_s2_q[DATA_W+MASK_W +: ADDR_W];
  wire [DATA_W-1:0] s_din = pin_s2_q[MASK_W +: DATA_W];
  wire [MASK_W-1:0] s_mask_n = pin_s2_q[MASK_W-1:0];

  // ------------------------------------------------------------
  // link edge detection
  // ------------------------------------------------------------
  logic k_prev_q;
  logic kn_prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      k_prev_q <= 1'b1;
      kn_prev_q <= 1'b1;
    end else begin
      k_prev_q <= s_k;
      kn_prev_q <= s_kn;
    end
  end

  // falling edges are never looked at
  wire k_rise = s_k & ~k_prev_q;
  wire kn_rise = s_kn & ~kn_prev_q & ~k_rise;
  wire half = k_rise | kn_rise;

  // ------------------------------------------------------------
  // command capture
  // ------------------------------------------------------------
  logic rd_last_q;
  logic wr_last_q;
  qpbsi_pkg::qpbsi_cmd_t cmd;

  // one address per edge; a read blocks a read on the next edge,
  // and a read wins over a write offered on the same edge
  wire rd_take = k_rise & ~s_rd_n & ~rd_last_q;
  wire wr_take = k_rise & ~s_wr_n & ~wr_last_q & ~rd_take;

  assign cmd = rd_take ? qpbsi_pkg::cmd_read
    : wr_take ? qpbsi_pkg::cmd_write
    : qpbsi_pkg::cmd_idle;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_last_q <= 1'b0;
      wr_last_q <= 1'b0;
    end else if (k_rise) begin
      rd_last_q <= cmd == qpbsi_pkg::cmd_read;
      wr_last_q <= cmd == qpbsi_pkg::cmd_write;
    end
  end

  // ------------------------------------------------------------
  // half-cycle pipelines
  // ------------------------------------------------------------
  // stage i holds a request i+1 half-cycles old at the next edge
  logic [RP-1:0] rd_vld_q;
  logic [ADDR_W-1:0] rd_addr_q [0:RP-1];
  logic [WP-1:0] wr_vld_q;
  logic [ADDR_W-1:0] wr_addr_q [0:WP-1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_vld_q <= '0;
      wr_vld_q <= '0;
    end else if (half) begin
      rd_vld_q <= {rd_vld_q[RP-2:0], cmd == qpbsi_pkg::cmd_read};
      wr_vld_q <= {wr_vld_q[WP-2:0], cmd == qpbsi_pkg::cmd_write};
    end
  end

  always_ff @(posedge clk) begin
    if (half) begin
      rd_addr_q[0] <= s_addr;
      wr_addr_q[0] <= s_addr;
      for (int i = 1; i < RP; i++) begin
        rd_addr_q[i] <= rd_addr_q[i-1];
      end
      for (int i = 1; i < WP; i++) begin
        wr_addr_q[i] <= wr_addr_q[i-1];
      end
    end
  end

  // ------------------------------------------------------------
  // beat selection
  // ------------------------------------------------------------
  logic rd_hit;
  qpbsi_pkg::qpbsi_beat_t rd_beat;
  logic [ADDR_W-1:0] rd_baddr;
  logic wr_hit;
  qpbsi_pkg::qpbsi_beat_t wr_beat;
  logic [ADDR_W-1:0] wr_baddr;

  // dll bypass shortens the read by one full cycle
  wire [3:0] rd_lat = s_dll_n ? 4'(`QPBSI_RD_LAT_HALF)
    : 4'(`QPBSI_RD_LAT_HALF_DLLOFF);

  // requests of one kind are at least four half-cycles apart, so one stage hits
  always_comb begin
    rd_hit = 1'b0;
    rd_beat = '0;
    rd_baddr = '0;
    wr_hit = 1'b0;
    wr_beat = '0;
    wr_baddr = '0;
    for (int b = 0; b < BL; b++) begin
      if (half && rd_vld_q[int'(rd_lat) - 1 + b]) begin
        rd_hit = 1'b1;
        rd_beat = 2'(b);
        rd_baddr = rd_addr_q[int'(rd_lat) - 1 + b];
      end
      if (half && wr_vld_q[`QPBSI_WR_LAT_HALF - 1 + b]) begin
        wr_hit = 1'b1;
        wr_beat = 2'(b);
        wr_baddr = wr_addr_q[`QPBSI_WR_LAT_HALF - 1 + b];
      end
    end
  end

  // ------------------------------------------------------------
  // write buffer and array
  // ------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [0:(2**MW)-1];
  logic f_out_vld;
  logic [FW-1:0] f_out;
  logic f_in_rdy;

  wire [MW-1:0] f_addr = f_out[FW-1 -: MW];
  wire [MASK_W-1:0] f_mask_n = f_out[DATA_W +: MASK_W];
  wire [DATA_W-1:0] f_data = f_out[DATA_W-1:0];
  // the read fetch owns the array in its cycle, the drain waits
  wire f_out_rdy = ~rd_hit;
  wire f_pop = f_out_vld & f_out_rdy;

  qpbsi_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_hit),
    .in_ready(f_in_rdy),
    .in_data({wr_baddr, wr_beat, s_mask_n, s_din}),
    .out_valid(f_out_vld),
    .out_ready(f_out_rdy),
    .out_data(f_out)
  );

  assign wr_buf_ready = f_in_rdy;

  always_ff @(posedge clk) begin
    if (f_pop) begin
      mem_q[f_addr] <= byte_merge(mem_q[f_addr], f_data, f_mask_n);
    end
  end

  // ------------------------------------------------------------
  // read fetch and output
  // ------------------------------------------------------------
  wire [MW-1:0] rd_maddr = {rd_baddr, rd_beat};
  wire [DATA_W-1:0] rd_word = mem_q[rd_maddr];
  // a beat written on this very edge has not reached the array yet
  wire fwd = rd_hit & wr_hit & (rd_baddr == wr_baddr) & (rd_beat == wr_beat);
  wire [DATA_W-1:0] rd_merged = fwd
    ? byte_merge(rd_word, s_din, s_mask_n) : rd_word;

  logic [DATA_W-1:0] data_out_q;
  logic valid_q;
  logic echo_t_q;
  logic echo_c_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out_q <= '0;
      valid_q <= 1'b0;
    end else if (half) begin
      valid_q <= rd_hit;
      if (rd_hit) begin
        data_out_q <= rd_merged;
      end
    end
  end

  // echoes follow the sampled clocks on the same clk edge as data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      echo_t_q <= 1'b0;
      echo_c_q <= 1'b1;
    end else begin
      echo_t_q <= s_k;
      echo_c_q <= s_kn;
    end
  end

  assign data_out = data_out_q;
  assign data_out_oe = valid_q;
  assign read_data_valid = valid_q;
  assign echo_clock_true = echo_t_q;
  assign echo_clock_comp = echo_c_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // half-cycles elapsed since the last taken read
  logic [3:0] rd_h_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_h_q <= '1;
    end else if (cmd == qpbsi_pkg::cmd_read) begin
      rd_h_q <= '0;
    end else if (half && rd_h_q != 4'hF) begin
      rd_h_q <= rd_h_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rd_lat_norm: assert property (
    (rd_hit && rd_beat == 2'h0 && s_dll_n) |-> (k_rise && rd_h_q == 4'h3))
    else $error("first read beat not at third true edge");

  a_rd_lat_short: assert property (
    (rd_hit && rd_beat == 2'h0 && !s_dll_n) |-> (k_rise && rd_h_q == 4'h1))
    else $error("short latency first beat misplaced");

  a_rd_odd_comp: assert property (
    (rd_hit && rd_beat[0]) |-> kn_rise)
    else $error("even read beat not on complementary edge");

  a_wr_beat_phase: assert property (
    (wr_hit && !wr_beat[0]) |-> k_rise)
    else $error("odd write beat not on true edge");

  a_wr_span_two: assert property (
    (wr_hit && wr_beat == 2'h3) |-> (kn_rise && $past(wr_vld_q[4])))
    else $error("last write beat misplaced");

  a_cmd_slot_alt: assert property (
    rd_take |-> (rd_h_q >= 4'h3))
    else $error("read accepted on back to back edges");

  a_cmd_rise_only: assert property (
    (cmd != qpbsi_pkg::cmd_idle) |-> (k_rise && !kn_rise))
    else $error("command taken off a true rising edge");

  a_echo_align: assert property (
    $changed(data_out_q) |-> ($changed(echo_t_q) || $changed(echo_c_q)))
    else $error("read data moved without an echo edge");

  a_valid_edge: assert property (
    $rose(valid_q) |-> $changed(echo_t_q) || $changed(echo_c_q))
    else $error("valid rose off an echo edge");

  a_mask_keeps: assert property (
    (f_pop && &f_mask_n) |=> mem_q[$past(f_addr)] == $past(mem_q[f_addr]))
    else $error("fully masked beat changed the array");

endmodule : qpbsi_core

// *** hdl/qpbsi_fifo.sv ***
// parameterised valid/ready fifo holding write beats
// assumes: one clock, async active-low reset
`timescale 1ns/100ps
module qpbsi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic in_valid, // entry offered
  output logic in_ready, // room for an entry
  input wire logic [WIDTH-1:0] in_data, // offered entry
  output logic out_valid, // entry available
  input wire logic out_ready, // drain takes the entry
  output logic [WIDTH-1:0] out_data // oldest entry
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [0:DEPTH-1];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire same_slot = wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0];
  wire full = same_slot & (wr_ptr_q[AW] != rd_ptr_q[AW]);
  wire empty = wr_ptr_q == rd_ptr_q;

  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule : qpbsi_fifo

// *** hdl/qpbsi_pkg.sv ***
// types shared by the burst-4 sram port
// assumes: compiled before every other design file
package qpbsi_pkg;

  // command taken on a true-clock rising edge
  typedef enum logic [1:0] {
    cmd_idle,
    cmd_read,
    cmd_write
  } qpbsi_cmd_t;

  typedef logic [1:0] qpbsi_beat_t;

endpackage : qpbsi_pkg
